/* hdl/cid_core.sv */
// Instruction decode, cycle timing and file-skip execution.
// Assumes program word and file data are stable through each instruction cycle.
`timescale 1ns/100ps
module cid_core
  import cid_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // Configuration
  input  wire logic            ext_enable,
  input  wire logic [3:0]      bank_select_register,
  // Fetch side
  input  wire logic [15:0]     instr_word,
  output logic                 fetch_advance,
  // Data side
  input  wire logic [7:0]      file_rdata,
  input  wire logic [7:0]      working_register,
  output cid_operand_type      operand,
  output cid_result_type       result,
  output logic                 skip_active,
  output logic [1:0]           quarter_idx
);

  // Field helpers used by several decodes
  function automatic logic is_second_word(input logic [15:0] w);
    is_second_word = (w[15:12] == SECOND_WORD_TAG);
  endfunction

  function automatic logic is_double_word(input logic [15:0] w, input logic ext);
    is_double_word = (w[15:12] == DW_MOVFF_MSK) || (w[15:9] == DW_CALL_HI) ||
                     (w[15:8] == DW_GOTO_HI) || (w[15:8] == DW_LFSR_HI) ||
                     (ext && w[15:8] == EXT_PREFIX_HI);
  endfunction

  cid_quarter_type  q_r, q_nxt;
  logic [1:0]       idle_r;          // forced no-op cycles still owed
  logic [1:0]       idle_nxt;
  logic             in_dw_r;         // executing second half of double word
  logic [7:0]       fdata_r;
  // Operand and result flops, one small group each
  logic             dest_r;
  logic             banked_r;
  logic [3:0]       bank_r;
  logic             indexed_r;
  logic [2:0]       bit_r;
  logic [7:0]       addr_r;
  logic             we_file_r;
  logic             we_work_r;
  logic [7:0]       data_r;

  // Decode of the current word
  wire logic        op_cmp  = (instr_word[15:9] == OP_CMP_SKIP_EQ);
  wire logic        op_decz = (instr_word[15:10] == OP_DEC_SKIP_Z);
  wire logic        op_decn = (instr_word[15:10] == OP_DEC_SKIP_NZ);
  wire logic        is_dw   = is_double_word(instr_word, ext_enable);
  wire logic        lone_2w = is_second_word(instr_word) && !in_dw_r;
  wire logic        busy    = (idle_r != 2'h0) || in_dw_r || lone_2w;
  wire logic [7:0]  dec_val = fdata_r - 8'h01;
  wire logic        take_skip = !busy && ((op_cmp && fdata_r == working_register) ||
                                (op_decz && dec_val == ZERO_BYTE) ||
                                (op_decn && dec_val != ZERO_BYTE));

  wire logic        fld_dest    = instr_word[9];
  wire logic        fld_access  = instr_word[8];
  wire logic [2:0]  fld_bit     = instr_word[11:9];
  wire logic [7:0]  fld_addr    = instr_word[7:0];
  // Bank select register only when banked
  wire logic [3:0]  fld_bank    = fld_access ? bank_select_register : 4'h0;
  wire logic        fld_indexed = ext_enable && !fld_access && (fld_addr <= INDEXED_F_MAX);
  // Decrements store only outside idle and second-word cycles
  wire logic        dec_store   = !busy && (op_decz || op_decn);
  wire logic        at_decode   = (q_r == CID_Q_DECODE);
  wire logic        at_write    = (q_r == CID_Q_WRITE);

  always_comb begin
    case (q_r)
      CID_Q_DECODE:  q_nxt = CID_Q_READ;
      CID_Q_READ:    q_nxt = CID_Q_PROCESS;
      CID_Q_PROCESS: q_nxt = CID_Q_WRITE;
      CID_Q_WRITE:   q_nxt = CID_Q_DECODE;
      default:       q_nxt = CID_Q_DECODE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) q_r <= CID_Q_DECODE;
    else         q_r <= q_nxt;
  end

  // Skip cost: one idle cycle per taken skip
  always_comb begin
    idle_nxt = idle_r;
    if (q_r == CID_Q_WRITE) begin
      if (idle_r != 2'h0)  idle_nxt = idle_r - 2'h1;
      else if (take_skip)  idle_nxt = 2'h1;
    end
  end

  // Working state; double words take the second word as an extra cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_r  <= 2'h0;
      in_dw_r <= 1'b0;
      fdata_r <= 8'h00;
    end else begin
      idle_r <= idle_nxt;
      if (q_r == CID_Q_READ) fdata_r <= file_rdata;
      if (q_r == CID_Q_WRITE) in_dw_r <= !busy && is_dw;
      // Skipped double word adds its second cycle
      else if (q_r == CID_Q_DECODE && idle_r == 2'h1 && is_dw) in_dw_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dest_r <= 1'b0;
    end else if (at_decode) begin
      dest_r <= fld_dest;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      banked_r <= 1'b0;
    end else if (at_decode) begin
      banked_r <= fld_access;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank_r <= 4'h0;
    end else if (at_decode) begin
      bank_r <= fld_bank;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      indexed_r <= 1'b0;
    end else if (at_decode) begin
      indexed_r <= fld_indexed;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_r <= 3'h0;
    end else if (at_decode) begin
      bit_r <= fld_bit;
    end
  end

  // File address; the data side reads through it in the read quarter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= 8'h00;
    end else if (at_decode) begin
      addr_r <= fld_addr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      we_file_r <= 1'b0;
      we_work_r <= 1'b0;
    end else begin
      we_file_r <= at_write && dec_store && fld_dest;
      we_work_r <= at_write && dec_store && !fld_dest;
    end
  end

  // Result byte; meaningful only under a write pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_r <= 8'h00;
    end else if (at_write) begin
      data_r <= dec_val;
    end
  end

  // Extension gates the E8 prefix double-word decode and the indexed decode
  assign fetch_advance = at_write;
  assign operand       = '{dest_file: dest_r, banked: banked_r, indexed: indexed_r, bit_num: bit_r,
                           file_addr: addr_r, bank: bank_r};
  assign result        = '{we_file: we_file_r, we_work: we_work_r, data: data_r};
  assign skip_active   = (idle_r != 2'h0);
  assign quarter_idx   = (q_r == CID_Q_DECODE)  ? 2'h0 :
                         (q_r == CID_Q_READ)    ? 2'h1 :
                         (q_r == CID_Q_PROCESS) ? 2'h2 : QUARTERS;

endmodule // cid_core

/* hdl/cid_pkg.sv */
// Constants, types and encodings for the instruction decode and skip block.
// Assumes an 8-bit Harvard core with 16-bit program words and a 50 MHz clock.
// Contract
// - Base set plus eight-instruction extension enable
// - Single 16-bit words; four double-word forms
// - Second word recognised by top nibble ones
// - Lone second word executes as no-op
// - One cycle; two when taken or branching
// - Double-word instructions always take two cycles
// - Instruction cycle is four clock periods
// - Destination bit picks working register or file
// - Bit field selects affected bit position
// - Access bit picks access bank or banked
// - Extension, access zero, f<=95: indexed offset
// - Compare-skip-equal discards prefetch on equality
// - Skip costs one, two, or three cycles
package cid_pkg;

  localparam logic [3:0] SECOND_WORD_TAG  = 4'hF;
  localparam logic [6:0] OP_CMP_SKIP_EQ   = 7'h31;   // 0110 001
  localparam logic [5:0] OP_DEC_SKIP_Z    = 6'h0B;   // 0010 11
  localparam logic [5:0] OP_DEC_SKIP_NZ   = 6'h13;   // 0100 11
  localparam logic [7:0] INDEXED_F_MAX    = 8'h5F;   // 95
  localparam logic [1:0] QUARTERS         = 2'h3;    // last quarter index
  // Double-word first words (top byte patterns)
  localparam logic [7:0] DW_MOVFF_HI      = 8'hC0;   // 1100 xxxx
  localparam logic [3:0] DW_MOVFF_MSK     = 4'hC;
  localparam logic [6:0] DW_CALL_HI       = 7'h76;   // 1110 110x
  localparam logic [7:0] DW_GOTO_HI       = 8'hEF;
  localparam logic [7:0] DW_LFSR_HI       = 8'hEE;
  localparam logic [7:0] EXT_PREFIX_HI    = 8'hE8;   // extension prefix, top byte E8 only
  localparam logic [7:0] ZERO_BYTE        = 8'h00;

  typedef enum logic [3:0] {
    CID_Q_DECODE  = 4'b0001,
    CID_Q_READ    = 4'b0010,
    CID_Q_PROCESS = 4'b0100,
    CID_Q_WRITE   = 4'b1000
  } cid_quarter_type;

  typedef struct packed {
    logic       dest_file;   // 1: write file, 0: working register
    logic       banked;      // 1: bank select register used
    logic       indexed;     // indexed literal offset mode
    logic [2:0] bit_num;
    logic [7:0] file_addr;
    logic [3:0] bank;
  } cid_operand_type;

  typedef struct packed {
    logic       we_file;
    logic       we_work;
    logic [7:0] data;
  } cid_result_type;

endpackage

/* verif/cid_core_properties.sv */
// Timing and write checks on the cid_core ports.
// Assumes one clock domain; bound to every cid_core.
`timescale 1ns/100ps
module cid_chk
  import cid_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Watched ports
  input wire logic        ext_enable,
  input wire logic [3:0]  bank_select_register,
  input wire logic [15:0] instr_word,
  input wire logic        fetch_advance,
  input wire logic [7:0]  file_rdata,
  input cid_operand_type  operand,
  input cid_result_type   result,
  input wire logic        skip_active,
  input wire logic [1:0]  quarter_idx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Write pulse, read quarter, expected bank and offset
  wire we = result.we_file | result.we_work;
  wire q1 = quarter_idx == 2'h1;
  wire [3:0] bk = instr_word[8] ? bank_select_register : 4'h0;
  wire idx = ext_enable && !instr_word[8] && instr_word[7:0] <= INDEXED_F_MAX;
  sequence q_walk;
    quarter_idx == 2'h0 ##1 q1 ##1 quarter_idx == 2'h2;
  endsequence
  quarter_run_a: assert property (quarter_idx == 2'h3 |=> q_walk) else $error("order");
  fetch_slot_a: assert property (fetch_advance == (quarter_idx == 2'h3)) else $error("fetch");
  write_slot_a: assert property (we |-> $past(quarter_idx) == 2'h3) else $error("slot");
  idle_quiet_a: assert property (skip_active && quarter_idx == 2'h3 |=> !we) else $error("idle");
  dest_pick_a: assert property (we |-> result.we_file == $past(operand.dest_file)) else $error("dest");
  cmp_quiet_a: assert property (we |-> $past(instr_word[15:9]) != OP_CMP_SKIP_EQ) else $error("cmp");
  lone_quiet_a: assert property (we |-> $past(instr_word[15:12]) != SECOND_WORD_TAG) else $error("lone");
  dec_value_a: assert property (we && $past(instr_word[15:10]) == OP_DEC_SKIP_Z |->
    result.data == $past(file_rdata) - 8'h01) else $error("dec");
  bank_pick_a: assert property (q1 |-> operand.bank == $past(bk)) else $error("bank");
  index_pick_a: assert property (q1 |-> operand.indexed == $past(idx)) else $error("index");
endmodule // cid_chk
bind cid_core cid_chk cid_chk_i (.clk, .resetn, .ext_enable, .bank_select_register, .instr_word,
  .fetch_advance, .file_rdata, .operand, .result, .skip_active, .quarter_idx);

/* verif/cid_mem.sv */
// Program store and data file model facing cid_core.
// Bench loads prog and mem while reset is held.
`timescale 1ns/100ps
module cid_mem
  import cid_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Core side
  input  wire logic       fetch_advance,
  input  cid_operand_type operand,
  input  cid_result_type  result,
  output logic [15:0]     instr_word,
  output logic [7:0]      file_rdata
);
  logic [15:0] prog [16];
  logic [7:0]  mem [256];
  logic [7:0]  wr_r;
  logic [3:0]  pc_r;
  assign instr_word = prog[pc_r];
  assign file_rdata = mem[operand.file_addr];
  // Pulse lands before the operand moves on
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= 4'h0;
    end else begin
      if (fetch_advance) pc_r <= pc_r + 4'h1;
      if (result.we_file) mem[operand.file_addr] <= result.data;
      if (result.we_work) wr_r <= result.data;
    end
  end
endmodule // cid_mem

/* verif/tb.sv */
// Bench for cid_core with the program and file model.
// Assumes a 50 MHz clock; files 10h..13h are scratch.
`timescale 1ns/100ps
module tb;
  import cid_pkg::*;
  typedef logic [15:0] cid_prog_type [16];
  logic            clk, resetn, ext_enable, fetch_advance, skip_active;
  logic [3:0]      bank_select_register;
  logic [15:0]     instr_word;
  logic [7:0]      file_rdata, working_register;
  logic [1:0]      quarter_idx;
  cid_operand_type operand;
  cid_result_type  result;
  int              bad_count, total_checks;
  cid_core cid_core_i (.clk, .resetn, .ext_enable, .bank_select_register, .instr_word,
    .fetch_advance, .file_rdata, .working_register, .operand, .result, .skip_active, .quarter_idx);
  cid_mem cid_mem_i (.clk, .resetn, .fetch_advance, .operand, .result, .instr_word, .file_rdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ck(input logic [7:0] got, want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Reset, load program and files 10h..13h, then run n slots
  task automatic go(input cid_prog_type p, input logic [7:0] a, b, c, d, input int n);
    int t;
    t = 0;
    resetn <= 1'b0;
    @(posedge clk);
    cid_mem_i.prog = p;
    cid_mem_i.mem = '{16: a, 17: b, 18: c, 19: d, default: 8'h00};
    @(posedge clk);
    resetn <= 1'b1;
    while (n > 0) begin
      @(negedge clk);
      t++;
      if (fetch_advance === 1'b1) n--;
      if (t > 99) begin
        bad_count++;
        close_out();
      end
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic s_zero();
    go('{0: 16'h2E10, 1: 16'h2E11, 2: 16'h2C12, default: 16'h0000}, 8'h01, 8'h05, 8'h09, 8'h00, 4);
    ck(cid_mem_i.mem[16], 8'h00);
    ck(cid_mem_i.mem[17], 8'h05);
    ck(cid_mem_i.wr_r, 8'h08);
  endtask
  task automatic s_nonzero();
    go('{0: 16'h4E10, 1: 16'h2E11, default: 16'h0000}, 8'h03, 8'h05, 8'h00, 8'h00, 3);
    ck(cid_mem_i.mem[16], 8'h02);
    ck(cid_mem_i.mem[17], 8'h05);
  endtask
  // Banked compare exercises the bank select path
  task automatic s_compare();
    go('{0: 16'h6312, 1: 16'h2E11, 2: 16'h6213, 3: 16'h2E10, default: 16'h0000}, 8'h05, 8'h05, 8'h22, 8'h30, 5);
    ck(cid_mem_i.mem[17], 8'h05);
    ck(cid_mem_i.mem[16], 8'h04);
  endtask
  task automatic s_double();
    go('{0: 16'h2E10, 1: 16'hEF00, 2: 16'hF000, 3: 16'h2E11, default: 16'h0000}, 8'h01, 8'h05, 8'h00, 8'h00, 5);
    ck(cid_mem_i.mem[17], 8'h04);
  endtask
  // Extension on: low access-bank words decode as offsets
  task automatic s_lone();
    ext_enable <= 1'b1;
    go('{0: 16'hFE11, 1: 16'h2E11, default: 16'h0000}, 8'h00, 8'h05, 8'h00, 8'h00, 3);
    ck(cid_mem_i.mem[17], 8'h04);
  endtask
  initial begin
    resetn = 1'b0;
    ext_enable <= 1'b0;
    bank_select_register <= 4'h5;
    working_register <= 8'h22;
    repeat (12) @(posedge clk);
    s_zero();
    s_nonzero();
    s_compare();
    s_double();
    s_lone();
    close_out();
  end
endmodule // tb
